// File: pkg/brk_qual_pkg.sv
/*
  constants for the channel a bus-cycle qualifier: register offsets,
  field positions, reset values and interrupt layout.
  assumes a 32-bit classic wishbone register bus with byte offsets.
*/
package brk_qual_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [3:0] qual_offset = 4'h0;
  localparam logic [3:0] addr_offset = 4'h4;
  localparam logic [3:0] mask_offset = 4'h8;
  localparam logic [3:0] status_offset = 4'hc;
  localparam logic [3:0] irq_mask_offset = 4'h0;
  localparam logic [1:0] irq_mask_word = 2'h0;
  // ==========================================================
  // qualifier field positions
  localparam int master_lsb = 6;
  localparam int access_lsb = 4;
  localparam int direction_lsb = 2;
  localparam int qual_width = 16;
  localparam int field_top = 7;
  // ==========================================================
  // reset values
  localparam logic [15:0] qual_reset = 16'h0000;
  localparam logic [31:0] word_reset = 32'h0000_0000;
  // ==========================================================
  // extra registers: interrupt mask at 0x10
  localparam logic [4:0] irq_mask_addr = 5'h10;
  localparam int status_match_bit = 0;
endpackage

// File: src/addr_compare.sv
/*
  masked 32-bit address compare for channel a.
  assumes address and stored values are stable for the compare cycle.
*/
`timescale 1ns/1ps
module addr_compare (
  input wire logic [31:0] bus_addr_i,
  input wire logic [31:0] break_address_i,
  input wire logic [31:0] break_address_mask_i,
  output logic hit_o
);
  logic [31:0] bit_ok;
  // ==========================================================
  // per-bit compare, a set mask bit drops the bit out
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign bit_ok[i] = break_address_mask_i[i] |
        (bus_addr_i[i] == break_address_i[i]);
    end
  endgenerate
  assign hit_o = &bit_ok;
endmodule

// File: src/break_bus_cycle_select_a.sv
/*
  channel a bus-cycle qualifier with wishbone register slave.
  assumes one observed bus cycle per clock marked by cyc_valid_i.
*/
`timescale 1ns/1ps
module break_bus_cycle_select_a (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cyc_valid_i,
  input wire logic [31:0] cyc_addr_i,
  input wire logic cyc_is_dma_i,
  input wire logic cyc_is_fetch_i,
  input wire logic cyc_is_write_i,
  output logic match_o,
  output logic irq_o
);
  typedef struct packed {
    logic [5:0] qual;
    logic [31:0] addr;
    logic [31:0] mask;
    logic status;
    logic irq_mask;
    logic [31:0] dat;
    logic ack;
    logic match;
    logic irq;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic addr_hit;
  logic master_ok;
  logic access_ok;
  logic direction_ok;
  logic qual_hit;
  logic access_go;
  logic [1:0] ms;
  logic [1:0] at;
  logic [1:0] dr;
  logic [31:0] wmask;

  addr_compare u_cmp (
    .bus_addr_i(cyc_addr_i),
    .break_address_i(st_reg.addr),
    .break_address_mask_i(st_reg.mask),
    .hit_o(addr_hit)
  );

  // ==========================================================
  // qualifier decode
  always_comb begin
    ms = st_reg.qual[5:4];
    at = st_reg.qual[3:2];
    dr = st_reg.qual[1:0];
    master_ok = cyc_is_dma_i ? (ms == 2'h2) : ms[0];
    case (at)
      2'h1: access_ok = cyc_is_fetch_i;
      2'h2: access_ok = !cyc_is_fetch_i;
      2'h3: access_ok = 1'b1;
      default: access_ok = 1'b0;
    endcase
    case (dr)
      2'h1: direction_ok = !cyc_is_write_i;
      2'h2: direction_ok = cyc_is_write_i;
      2'h3: direction_ok = 1'b1;
      default: direction_ok = 1'b0;
    endcase
    // a 00 field decodes to reject, so it blocks the match
    qual_hit = master_ok & access_ok & direction_ok;
  end

  // byte-lane write mask from sel
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // one ack per request; the cycle with ack high blocks a repeat
  assign access_go = wb_cyc_i & wb_stb_i & !st_reg.ack;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.ack = access_go;
    st_next.match = cyc_valid_i & addr_hit & qual_hit;
    // event sets sticky status
    if (st_next.match) begin
      st_next.status = 1'b1;
    end
    st_next.dat = brk_qual_pkg::word_reset;
    if (access_go) begin
      if (wb_we_i) begin
        case (wb_adr_i)
          {1'b0, brk_qual_pkg::qual_offset}: begin
            if (wb_sel_i[0]) begin
              st_next.qual = wb_dat_i[7:2];
            end
          end
          {1'b0, brk_qual_pkg::addr_offset}:
            st_next.addr = (st_reg.addr & ~wmask) | (wb_dat_i & wmask);
          {1'b0, brk_qual_pkg::mask_offset}:
            st_next.mask = (st_reg.mask & ~wmask) | (wb_dat_i & wmask);
          brk_qual_pkg::irq_mask_addr: begin
            if (wb_sel_i[0]) begin
              st_next.irq_mask = wb_dat_i[0];
            end
          end
          default: ;
        endcase
      end else begin
        case (wb_adr_i)
          // bits 31:8 and bits 1:0 read zero
          {1'b0, brk_qual_pkg::qual_offset}:
            st_next.dat = {24'h00_0000, st_reg.qual, 2'h0};
          {1'b0, brk_qual_pkg::addr_offset}: st_next.dat = st_reg.addr;
          {1'b0, brk_qual_pkg::mask_offset}: st_next.dat = st_reg.mask;
          {1'b0, brk_qual_pkg::status_offset}: begin
            st_next.dat = {31'h0, st_reg.status};
            // read clears, but a new match in this cycle survives
            st_next.status = st_next.match;
          end
          brk_qual_pkg::irq_mask_addr:
            st_next.dat = {31'h0, st_reg.irq_mask};
          default: st_next.dat = brk_qual_pkg::word_reset;
        endcase
      end
    end
    st_next.irq = st_next.status & st_next.irq_mask;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign match_o = st_reg.match;
  assign irq_o = st_reg.irq;

  // ==========================================================
  // checks; each watches the registered outputs or state one edge after the cause
  chk_dma_master_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && cyc_is_dma_i && st_reg.qual[5:4] != 2'h2
    |=> !match_o)
    else $error("dma match without 10 master");
  chk_cpu_master_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && !cyc_is_dma_i && !st_reg.qual[4]
    |=> !match_o)
    else $error("cpu match without x1 master");
  chk_fetch_access_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && cyc_is_fetch_i && !st_reg.qual[2]
    |=> !match_o)
    else $error("fetch match while not selected");
  chk_data_access_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && !cyc_is_fetch_i && !st_reg.qual[3]
    |=> !match_o)
    else $error("data match while not selected");
  chk_direction_sel: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && (cyc_is_write_i ? !st_reg.qual[1] : !st_reg.qual[0])
    |=> !match_o)
    else $error("direction not selected");
  chk_addr_mask_cmp: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && |((cyc_addr_i ^ st_reg.addr) & ~st_reg.mask)
    |=> !match_o)
    else $error("match despite address miss");
  chk_zero_field_block: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && (st_reg.qual[5:4] == 2'h0 || st_reg.qual[3:2] == 2'h0
    || st_reg.qual[1:0] == 2'h0)
    |=> !match_o)
    else $error("match with a field left at 00");
  // full match is decoded here again from the field codes, not from qual_hit,
  // so a broken decoder cannot agree with itself
  chk_full_match: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cyc_valid_i && ((cyc_addr_i ^ st_reg.addr) & ~st_reg.mask) == 32'h0
    && (cyc_is_dma_i ? st_reg.qual[5:4] == 2'h2 : st_reg.qual[4])
    && (cyc_is_fetch_i ? st_reg.qual[2] : st_reg.qual[3])
    && (cyc_is_write_i ? st_reg.qual[1] : st_reg.qual[0])
    |=> match_o)
    else $error("qualified cycle gave no match");
  chk_upper_byte_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    access_go && !wb_we_i && wb_adr_i == 5'h00
    |=> wb_ack_o && wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  chk_field_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    access_go && wb_we_i && wb_adr_i == 5'h00 && wb_sel_i[0]
    |=> st_reg.qual == $past(wb_dat_i[7:2]))
    else $error("qual not written");
  // reset is not a disable here: the check is about the reset itself
  chk_reset_clear: assert property (
    @(posedge clk_i)
    rst_i |=> st_reg.qual == 6'h00 && !wb_ack_o && !match_o && !irq_o)
    else $error("state not cleared by reset");
  // one ack per request, never two in a row
  chk_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
  // the interrupt level stays until status is read or the mask is written
  chk_irq_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_o && !(access_go && wb_adr_i == 5'h0c && !wb_we_i)
    && !(access_go && wb_adr_i == 5'h10 && wb_we_i)
    |=> irq_o)
    else $error("interrupt dropped without a status read");
endmodule

// File: bench/bus_cycle_source.sv
/*
  far-side model: emits one observed bus cycle on request.
  assumes the bench raises req_i for exactly one clock per cycle.
*/
`timescale 1ns/1ps
module bus_cycle_source (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic [2:0] kind_i,
  output logic valid_o,
  output logic [31:0] addr_o,
  output logic [2:0] kind_o
);
  // ==========================================
  // idle lines churn so a stale attribute never looks valid
  initial begin
    valid_o = 1'b0;
    addr_o = 32'h0000_0000;
    kind_o = 3'b000;
  end
  always @(posedge clk_i) begin
    valid_o <= req_i;
    addr_o <= req_i ? addr_i : ~addr_o;
    kind_o <= req_i ? kind_i : ~kind_o;
  end
endmodule

// File: bench/break_bus_cycle_select_a_tb.sv
/*
  self-checking bench for the channel a cycle qualifier.
  assumes a one-cycle wishbone ack and a one-cycle match latency.
*/
`timescale 1ns/1ps
module break_bus_cycle_select_a_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req, im, em;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, sl;
  logic [31:0] wb_dat_i, wb_dat_o, ca, ba, bm, q, pa;
  logic wb_ack_o, v, match_o, irq_o;
  logic [2:0] k, pk;
  logic [7:0] qf;
  int fail_count, checked;
  // ==========================================
  // clock, model and design
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  bus_cycle_source src (.clk_i(clk_i), .req_i(req), .addr_i(ca),
    .kind_i(k), .valid_o(v), .addr_o(pa), .kind_o(pk));
  break_bus_cycle_select_a DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cyc_valid_i(v),
    .cyc_addr_i(pa), .cyc_is_dma_i(pk[2]), .cyc_is_fetch_i(pk[1]),
    .cyc_is_write_i(pk[0]), .match_o(match_o), .irq_o(irq_o));
  // ==========================================
  // helpers; the match model is derived from the field codes
  function automatic logic exp_match(logic [7:0] f, logic [31:0] a,
    logic [31:0] b, logic [31:0] m, logic [2:0] c);
    logic ms;
    ms = c[2] ? (f[7:6] == 2'b10) : f[6];
    return ms && (c[1] ? f[4] : f[5]) && (c[0] ? f[3] : f[2])
      && (((a ^ b) & ~m) == 32'h0000_0000);
  endfunction
  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb_io(input logic we, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sl;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, req, k} = '0;
    wb_adr_i = 5'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hf;
    sl = 4'hf;
    ca = 32'h0000_0000;
    fail_count = 0;
    checked = 0;
    q = $urandom(32'h53ce);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_io(1'b0, 5'h00, 32'h0, q);
    check("qual_reset", q, 32'h0000_0000);
    wb_io(1'b1, 5'h00, 32'hffff_00ff, q);
    wb_io(1'b0, 5'h00, 32'h0, q);
    check("qual_fields", q, 32'h0000_00fc);
    // lane 0 off: the qualifier byte must keep its old fields
    sl = 4'he;
    wb_io(1'b1, 5'h00, 32'h0000_0000, q);
    sl = 4'hf;
    wb_io(1'b0, 5'h00, 32'h0, q);
    check("qual_lane", q, 32'h0000_00fc);
    wb_io(1'b0, 5'h14, 32'h0, q);
    check("unmapped", q, 32'h0000_0000);
    // random fields, masks and cycle kinds, with exact-hit corners
    for (int i = 0; i < 80; i++) begin
      qf = 8'($urandom_range(63)) << 2;
      ba = $urandom;
      bm = (i < 8) ? 32'h0 : $urandom;
      ca = (i % 5 == 4) ? $urandom : ba ^ ($urandom & bm);
      k = 3'($urandom);
      im = 1'($urandom);
      wb_io(1'b1, 5'h00, {24'h0, qf}, q);
      wb_io(1'b1, 5'h04, ba, q);
      wb_io(1'b1, 5'h08, bm, q);
      wb_io(1'b1, 5'h10, {31'h0, im}, q);
      wb_io(1'b0, 5'h00, 32'h0, q);
      check("qual", q, {24'h0, qf});
      wb_io(1'b0, 5'h04, 32'h0, q);
      check("addr", q, ba);
      wb_io(1'b0, 5'h08, 32'h0, q);
      check("mask", q, bm);
      em = exp_match(qf, ca, ba, bm, k);
      @(posedge clk_i);
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      @(posedge clk_i);
      #1;
      check("match", match_o, em);
      check("irq", irq_o, em & im);
      wb_io(1'b0, 5'h0c, 32'h0, q);
      check("status", q, {31'h0, em});
      @(posedge clk_i);
      #1;
      check("irq_clr", irq_o, 1'b0);
    end
    // mid-run reset must bring every field back to zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_io(1'b0, 5'h00, 32'h0, q);
    check("qual_rst2", q, 32'h0000_0000);
    wrap_up();
  end
endmodule
